//--- include/flow_pkg.sv
package flow_pkg;
	// status register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// bit positions inside an 8-bit operand
	localparam int MSB = 7;
	localparam int NIB_MSB = 3;
	// cycle counts
	localparam logic [1:0] CALL_CYCLES = 2'h3;
	localparam logic [1:0] BRANCH_TAKEN_CYCLES = 2'h2;
	// pc increments
	localparam logic [15:0] PC_ONE = 16'h0001;
	localparam logic [15:0] PC_TWO = 16'h0002;
	localparam logic [15:0] PC_THREE = 16'h0003;
	// operation select codes
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_REL_CALL = 5'h01,
		OP_PTR_CALL = 5'h02,
		OP_CMP_SKIP_EQ = 5'h03,
		OP_CMP_REG = 5'h04,
		OP_CMP_CARRY = 5'h05,
		OP_CMP_IMM = 5'h06,
		OP_SKIP_REG_CLR = 5'h07,
		OP_SKIP_REG_SET = 5'h08,
		OP_SKIP_IO_CLR = 5'h09,
		OP_SKIP_IO_SET = 5'h0A,
		OP_BR_FLAG_SET = 5'h0B,
		OP_BR_FLAG_CLR = 5'h0C
	} op_t;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01
	} seq_state_t;
endpackage

//--- verilog/flow_compare.sv
`timescale 1ns/1ps
`default_nettype none
// subtract for compare: result discarded, flags produced
module flow_compare (
	// operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic use_carry,
	input wire logic carry_in,
	input wire logic zero_in,
	// flag results
	output logic flag_z,
	output logic flag_n,
	output logic flag_v,
	output logic flag_c,
	output logic flag_h,
	output logic flag_s
);
	logic [7:0] r; // difference
	logic cin; // borrow in
	always_comb begin
		cin = use_carry & carry_in;
		r = a - b - {7'h00, cin};
		flag_n = r[flow_pkg::MSB];
		// carry-chained compare only keeps zero if previous was zero
		flag_z = (r == 8'h00) & (~use_carry | zero_in);
		flag_v = (a[flow_pkg::MSB] & ~b[flow_pkg::MSB] & ~r[flow_pkg::MSB])
			| (~a[flow_pkg::MSB] & b[flow_pkg::MSB] & r[flow_pkg::MSB]);
		flag_c = (~a[flow_pkg::MSB] & b[flow_pkg::MSB]) | (b[flow_pkg::MSB] & r[flow_pkg::MSB])
			| (r[flow_pkg::MSB] & ~a[flow_pkg::MSB]);
		flag_h = (~a[flow_pkg::NIB_MSB] & b[flow_pkg::NIB_MSB]) | (b[flow_pkg::NIB_MSB] & r[flow_pkg::NIB_MSB])
			| (r[flow_pkg::NIB_MSB] & ~a[flow_pkg::NIB_MSB]);
		flag_s = flag_n ^ flag_v;
	end
endmodule // flow_compare
`default_nettype wire

//--- verilog/flow_control_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module flow_control_branch_unit (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// instruction request
	input wire logic start,
	input wire flow_pkg::op_t op,
	input wire logic [11:0] rel_offset,
	input wire logic [2:0] bit_sel,
	input wire logic next_is_two_word,
	// operands
	input wire logic [7:0] reg_d,
	input wire logic [7:0] reg_r,
	input wire logic [7:0] imm_k,
	input wire logic [7:0] io_value,
	input wire logic [15:0] z_pointer,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] status_in,
	// status
	output logic busy,
	output logic done,
	// program counter
	output logic pc_load,
	output logic [15:0] pc_out,
	// call return address push
	output logic push_return,
	output logic [15:0] return_addr,
	// flags
	output logic status_load,
	output logic [7:0] status_out,
	// skip indication
	output logic skip_taken
);
	flow_pkg::seq_state_t state_q; // sequencer state
	logic [1:0] left_q; // remaining busy cycles
	logic [15:0] pc_q; // latched target
	logic [15:0] ret_q; // latched return address
	logic pc_load_q; // target valid
	logic push_q; // push strobe
	logic [7:0] status_q; // flag result
	logic status_load_q; // flag strobe
	logic skip_q; // skip decided
	logic done_q; // completion strobe
	// compare datapath outputs
	logic cz, cn, cv, cc, ch, cs;
	logic [7:0] cmp_b; // subtrahend
	logic use_c; // chain carry in
	// decode results
	logic cond; // branch/skip condition
	logic [15:0] rel_target; // pc+offset+1
	logic [15:0] skip_target; // pc+2 or pc+3
	logic is_cmp, is_skip, is_branch, is_call;
	logic [1:0] cycles; // extra cycles after the first
	// request qualifiers shared by the result processes
	logic take; // request accepted this edge
	logic br_hit; // branch condition true
	logic skip_hit; // skip condition true
	// sign-extend the 12-bit offset and add one
	function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [11:0] k);
		rel_add = pc + {{4{k[11]}}, k} + flow_pkg::PC_ONE;
	endfunction
	// select a bit of an 8-bit value
	function automatic logic bit_of(input logic [7:0] v, input logic [2:0] s);
		bit_of = v[s];
	endfunction
	// compare operand and carry selection
	always_comb begin
		cmp_b = (op == flow_pkg::OP_CMP_IMM) ? imm_k : reg_r;
		use_c = (op == flow_pkg::OP_CMP_CARRY);
	end
	// one subtractor serves all three compares
	flow_compare u_cmp (
		.a(reg_d),
		.b(cmp_b),
		.use_carry(use_c),
		.carry_in(status_in[flow_pkg::FLAG_C]),
		.zero_in(status_in[flow_pkg::FLAG_Z]),
		.flag_z(cz),
		.flag_n(cn),
		.flag_v(cv),
		.flag_c(cc),
		.flag_h(ch),
		.flag_s(cs)
	);
	// condition decode for skips and branches
	always_comb begin
		cond = 1'b0;
		is_cmp = 1'b0;
		is_skip = 1'b0;
		is_branch = 1'b0;
		is_call = 1'b0;
		unique case (op)
			// calls only set the cycle count here
			flow_pkg::OP_REL_CALL, flow_pkg::OP_PTR_CALL: begin
				is_call = 1'b1;
			end
			// equal registers skip the follower
			flow_pkg::OP_CMP_SKIP_EQ: begin
				is_skip = 1'b1;
				cond = (reg_d == reg_r);
			end
			// compares only touch the flags
			flow_pkg::OP_CMP_REG, flow_pkg::OP_CMP_CARRY, flow_pkg::OP_CMP_IMM: begin
				is_cmp = 1'b1;
			end
			// bit tests on a general register
			flow_pkg::OP_SKIP_REG_CLR: begin
				is_skip = 1'b1;
				cond = ~bit_of(reg_r, bit_sel);
			end
			flow_pkg::OP_SKIP_REG_SET: begin
				is_skip = 1'b1;
				cond = bit_of(reg_r, bit_sel);
			end
			// bit tests on an i/o value
			flow_pkg::OP_SKIP_IO_CLR: begin
				is_skip = 1'b1;
				cond = ~bit_of(io_value, bit_sel);
			end
			flow_pkg::OP_SKIP_IO_SET: begin
				is_skip = 1'b1;
				cond = bit_of(io_value, bit_sel);
			end
			// named branches map onto flag select: Z=1 eq, C=0 lo/cs, N=2 mi, S=4 ge/lt, H=5, T=6, V=3
			flow_pkg::OP_BR_FLAG_SET: begin
				is_branch = 1'b1;
				cond = bit_of(status_in, bit_sel);
			end
			flow_pkg::OP_BR_FLAG_CLR: begin
				is_branch = 1'b1;
				cond = ~bit_of(status_in, bit_sel);
			end
			// no-op and unused codes do nothing
			default: begin
				cond = 1'b0;
			end
		endcase
	end
	// targets and cycle count
	always_comb begin
		// relative target serves relative calls and branches alike
		rel_target = rel_add(pc_in, rel_offset);
		// a skip steps over a one- or two-word follower
		skip_target = pc_in + (next_is_two_word ? flow_pkg::PC_THREE : flow_pkg::PC_TWO);
		// single cycle unless a case below stretches it
		cycles = 2'h0;
		if (is_call) begin
			// calls always run their full length
			cycles = flow_pkg::CALL_CYCLES - 2'h1;
		end else if (br_hit) begin
			// a taken branch costs one refill cycle
			cycles = flow_pkg::BRANCH_TAKEN_CYCLES - 2'h1;
		end else if (skip_hit) begin
			// the skipped follower's words are paid as extra cycles
			cycles = next_is_two_word ? 2'h2 : 2'h1;
		end
	end
	// acceptance and hit decode shared by the result processes
	always_comb begin
		// a request while busy is dropped without notice
		take = start && (state_q == flow_pkg::ST_IDLE);
		br_hit = is_branch && cond;
		skip_hit = is_skip && cond;
	end
	// sequencer: counts out the multi-cycle instructions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// idle with nothing pending
			state_q <= flow_pkg::ST_IDLE;
			left_q <= 2'h0;
		end else begin
			unique case (state_q)
				flow_pkg::ST_IDLE: begin
					// single-cycle work never leaves idle
					if (take && cycles != 2'h0) begin
						state_q <= flow_pkg::ST_BUSY;
						left_q <= cycles;
					end
				end
				flow_pkg::ST_BUSY: begin
					// the last extra cycle hands back to idle
					if (left_q == 2'h1) begin
						state_q <= flow_pkg::ST_IDLE;
					end
					left_q <= left_q - 2'h1;
				end
				default: begin
					// an illegal code recovers to idle
					state_q <= flow_pkg::ST_IDLE;
				end
			endcase
		end
	end
	// program counter result and return push
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// no target until the first redirect
			pc_q <= 16'h0000;
			ret_q <= 16'h0000;
			pc_load_q <= 1'b0;
			push_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			// strobes last one cycle unless renewed below
			pc_load_q <= 1'b0;
			push_q <= 1'b0;
			skip_q <= 1'b0;
			if (take) begin
				if (op == flow_pkg::OP_REL_CALL) begin
					// relative call: jump and push the next address
					pc_q <= rel_target;
					ret_q <= pc_in + flow_pkg::PC_ONE;
					pc_load_q <= 1'b1;
					push_q <= 1'b1;
				end else if (op == flow_pkg::OP_PTR_CALL) begin
					// pointer call: jump to the pointer pair
					pc_q <= z_pointer;
					ret_q <= pc_in + flow_pkg::PC_ONE;
					pc_load_q <= 1'b1;
					push_q <= 1'b1;
				end else if (br_hit) begin
					// taken branch: redirect only, nothing pushed
					pc_q <= rel_target;
					pc_load_q <= 1'b1;
				end else if (skip_hit) begin
					// taken skip: step past the follower
					pc_q <= skip_target;
					pc_load_q <= 1'b1;
					skip_q <= 1'b1;
				end
				// anything else leaves the held target alone
			end
		end
	end
	// flag update for compares
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// flags start clear
			status_q <= 8'h00;
			status_load_q <= 1'b0;
		end else begin
			status_load_q <= 1'b0;
			if (take && is_cmp) begin
				// interrupt and transfer bits pass through unchanged
				status_q <= status_in;
				// the difference is thrown away, only flags land
				status_q[flow_pkg::FLAG_Z] <= cz;
				status_q[flow_pkg::FLAG_N] <= cn;
				status_q[flow_pkg::FLAG_V] <= cv;
				status_q[flow_pkg::FLAG_C] <= cc;
				status_q[flow_pkg::FLAG_H] <= ch;
				status_q[flow_pkg::FLAG_S] <= cs;
				status_load_q <= 1'b1;
			end
		end
	end
	// completion strobe at the end of the last cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// no completion pending
			done_q <= 1'b0;
		end else begin
			// single-cycle work ends at once, longer work on its last extra cycle
			done_q <= (take && cycles == 2'h0)
				|| (state_q == flow_pkg::ST_BUSY && left_q == 2'h1);
		end
	end
	// outputs: busy decoded from the state, the rest from registers
	assign busy = (state_q == flow_pkg::ST_BUSY);
	assign done = done_q;
	// program counter and return address
	assign pc_load = pc_load_q;
	assign pc_out = pc_q;
	assign push_return = push_q;
	assign return_addr = ret_q;
	// flags and skip
	assign status_load = status_load_q;
	assign status_out = status_q;
	assign skip_taken = skip_q;
endmodule // flow_control_branch_unit
`default_nettype wire

//--- testbench/flow_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches call and branch targets, skip strobes and cycle counts
module flow_unit_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire flow_pkg::op_t op,
	input wire logic [11:0] rel_offset,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] io_value,
	input wire logic [15:0] z_pointer,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] status_in,
	// results
	input wire logic busy,
	input wire logic done,
	input wire logic pc_load,
	input wire logic [15:0] pc_out,
	input wire logic skip_taken
);
	// accepted request per kind, selected bits
	logic tk, rc, ic, sc, ss, bs, bc, io_b, fl_b;
	// relative target pc plus offset plus one
	logic [15:0] rel_t;
	assign tk = start && !busy;
	assign rc = tk && op == flow_pkg::OP_REL_CALL;
	assign ic = tk && op == flow_pkg::OP_PTR_CALL;
	assign sc = tk && op == flow_pkg::OP_SKIP_IO_CLR;
	assign ss = tk && op == flow_pkg::OP_SKIP_IO_SET;
	assign bs = tk && op == flow_pkg::OP_BR_FLAG_SET;
	assign bc = tk && op == flow_pkg::OP_BR_FLAG_CLR;
	assign io_b = io_value[bit_sel];
	assign fl_b = status_in[bit_sel];
	assign rel_t = pc_in + {{4{rel_offset[11]}}, rel_offset} + 16'h0001;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_call_pc: assert property (rc |=> pc_load && pc_out == $past(rel_t))
		else $error("bad call target");
	a_pointer_indirect_call_pc: assert property (ic |=> pc_load && pc_out == $past(z_pointer))
		else $error("bad indirect target");
	a_call_done: assert property (rc || ic |=> !done [*2] ##1 done)
		else $error("bad call length");
	a_call_busy: assert property (rc || ic |=> busy [*2] ##1 !busy)
		else $error("bad call busy");
	a_skip_clr: assert property (sc |=> skip_taken == !$past(io_b))
		else $error("bad clear skip");
	a_skip_set: assert property (ss |=> skip_taken == $past(io_b))
		else $error("bad set skip");
	a_branch_taken: assert property (bs && fl_b || bc && !fl_b |=> pc_load && !done && pc_out == $past(rel_t) ##1 done)
		else $error("bad taken branch");
	a_branch_fall: assert property (bs && !fl_b || bc && fl_b |=> done && !pc_load)
		else $error("bad untaken branch");
endmodule // flow_unit_chk
bind flow_control_branch_unit flow_unit_chk chk (.clk, .rst, .start, .op, .rel_offset, .bit_sel, .io_value,
	.z_pointer, .pc_in, .status_in, .busy, .done, .pc_load, .pc_out, .skip_taken);
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// runs each operation kind and judges targets, flags and lengths
module tb;
	// inputs, all set at time zero
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, next_is_two_word = 1'b0;
	flow_pkg::op_t op = flow_pkg::OP_NONE;
	logic [11:0] rel_offset = 12'h000;
	logic [2:0] bit_sel = 3'h0;
	logic [7:0] reg_d = 8'h00, reg_r = 8'h00, imm_k = 8'h00, io_value = 8'h00, status_in = 8'h00;
	logic [15:0] z_pointer = 16'h0000, pc_in = 16'h0000;
	// outputs
	logic busy, done, pc_load, push_return, status_load, skip_taken;
	logic [15:0] pc_out, return_addr;
	logic [7:0] status_out;
	// counters, first-cycle strobe captures
	int err_total = 0, checks_done = 0, cyc = 0;
	logic pl, sk, fl, pu;
	flow_control_branch_unit uut (.clk, .rst, .start, .op, .rel_offset, .bit_sel, .next_is_two_word, .reg_d,
		.reg_r, .imm_k, .io_value, .z_pointer, .pc_in, .status_in, .busy, .done, .pc_load, .pc_out,
		.push_return, .return_addr, .status_load, .status_out, .skip_taken);
	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end
	// hang guard, far above the roughly 125 cycles used
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			final_report();
		end
	end
	// one counted comparison
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	// start one operation, wait for done, check its length
	task automatic go(input flow_pkg::op_t o, input logic [15:0] n);
		logic [15:0] c;
		op = o;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		c = 16'h0001;
		pl = pc_load;
		sk = skip_taken;
		fl = status_load;
		pu = push_return;
		while (done !== 1'b1 && c < 16'h0009) begin
			@(posedge clk);
			#1 c++;
		end
		chk("cycles", n, c);
	endtask
	// both calls, negative offset
	task automatic t_call();
		pc_in = 16'h1000;
		rel_offset = 12'hFFE;
		z_pointer = 16'h2345;
		go(flow_pkg::OP_REL_CALL, 16'h0003);
		chk("call pc", 16'h0FFF, pc_out);
		chk("call push", 16'h0001, {15'h0, pu});
		chk("call ret", 16'h1001, return_addr);
		pc_in = 16'h1100;
		go(flow_pkg::OP_PTR_CALL, 16'h0003);
		chk("pointer_indirect_call pc", 16'h2345, pc_out);
		chk("pointer_indirect_call push", 16'h0001, {15'h0, pu});
		chk("pointer_indirect_call ret", 16'h1101, return_addr);
	endtask
	// one compare, flags checked whole
	task automatic cmp(input flow_pkg::op_t o, input logic [7:0] d, input logic [7:0] k, input logic [7:0] s, input logic [7:0] e);
		reg_d = d;
		reg_r = (o == flow_pkg::OP_CMP_IMM) ? ~k : k;
		imm_k = (o == flow_pkg::OP_CMP_IMM) ? k : ~k;
		status_in = s;
		go(o, 16'h0001);
		chk("flags", {1'b1, 7'h00, e}, {fl, 7'h00, status_out});
	endtask
	// borrow, overflow and carry chain cases
	task automatic t_cmp();
		cmp(flow_pkg::OP_CMP_IMM, 8'h10, 8'h20, 8'hC0, 8'hD5);
		cmp(flow_pkg::OP_CMP_IMM, 8'h80, 8'h01, 8'h00, 8'h38);
		cmp(flow_pkg::OP_CMP_CARRY, 8'h05, 8'h05, 8'h03, 8'h35);
		cmp(flow_pkg::OP_CMP_CARRY, 8'h06, 8'h05, 8'h03, 8'h02);
		cmp(flow_pkg::OP_CMP_CARRY, 8'h06, 8'h05, 8'h01, 8'h00);
		cmp(flow_pkg::OP_CMP_REG, 8'h06, 8'h05, 8'h03, 8'h00);
	endtask
	// bit skips on both bit values, one and two word followers
	task automatic t_skip();
		logic h;
		reg_d = 8'hA5;
		reg_r = 8'hA5;
		io_value = 8'h5A;
		pc_in = 16'h0200;
		for (int i = 0; i < 18; i++) begin
			bit_sel = {2'b00, i[0]};
			next_is_two_word = i[1];
			h = i[0] ^ i[2] ^ i[3] || i > 15;
			if (i == 17) reg_d = 8'hA4;
			go(i > 15 ? flow_pkg::OP_CMP_SKIP_EQ : flow_pkg::op_t'(5'h07 + {3'h0, i[3:2]}),
				h && i != 17 ? (i[1] ? 16'h0003 : 16'h0002) : 16'h0001);
			chk("skip", {15'h0, h && i != 17}, {15'h0, sk});
			if (h && i != 17) chk("skip pc", i[1] ? 16'h0203 : 16'h0202, pc_out);
		end
	endtask
	// every flag set and clear, three patterns with S equal to N xor V
	task automatic t_br();
		logic t;
		logic [7:0] s;
		pc_in = 16'h0100;
		rel_offset = 12'h040;
		for (int i = 0; i < 48; i++) begin
			s = (i < 16) ? 8'hB5 : ((i < 32) ? 8'h42 : 8'h5A);
			status_in = s;
			bit_sel = i[2:0];
			t = ((i[2:0] == flow_pkg::FLAG_S) ? s[flow_pkg::FLAG_N] ^ s[flow_pkg::FLAG_V] : s[i[2:0]]) ^ i[3];
			go(i[3] ? flow_pkg::OP_BR_FLAG_CLR : flow_pkg::OP_BR_FLAG_SET, t ? 16'h0002 : 16'h0001);
			chk("taken", {15'h0, t}, {15'h0, pl});
			if (t) chk("target", 16'h0141, pc_out);
			chk("branch push", 16'h0000, {15'h0, pu});
		end
	endtask
	// counts and verdict
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		t_call();
		t_cmp();
		t_skip();
		t_br();
		final_report();
	end
endmodule // tb
`default_nettype wire
